// ===== logic/fault_filter_pkg.sv
package fault_filter_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CHAN_FILT01_OFFS  = 8'h26;
    localparam logic [7:0] CHAN_FILT23_OFFS  = 8'h27;
    localparam logic [7:0] FAULT_FILT_OFFS   = 8'h28;
    localparam logic [7:0] FAULT_CTRL_OFFS   = 8'h29;
    localparam logic [7:0] FAULT_STAT_OFFS   = 8'h2a;
    localparam logic [7:0] MODE_CTRL_OFFS    = 8'h2b;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int ODD_VAL_LSB      = 4;
    localparam int EVEN_VAL_LSB     = 0;
    localparam int FILT_EN_LSB      = 4;
    localparam int INPUT_EN_LSB     = 0;
    localparam int STAT_SUMMARY_BIT = 7;
    localparam int STAT_INSTATE_BIT = 5;
    localparam int MODE_FAULT_BIT   = 0;
    localparam int MODE_WPOFF_BIT   = 1;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CHAN_FILT_RST  = 8'h00;
    localparam logic [3:0] FAULT_FILT_RST = 4'h0;
    localparam logic [7:0] FAULT_CTRL_RST = 8'h00;
    localparam logic [1:0] MODE_CTRL_RST  = 2'h0;

    // ------------------------------------------------------------------
    // filter timing: samples per filter step
    // ------------------------------------------------------------------
    localparam int FILT_SCALE = 4;

endpackage

// ===== logic/glitch_filter.sv
`timescale 1ns/1ps
// stable-level filter: output follows input after it stays put long enough
module glitch_filter
    import fault_filter_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // filter setting and data
    input  wire logic       enable,
    input  wire logic [3:0] filt_val,
    input  wire logic       din,
    output logic            dout
);

    logic [CNT_W-1:0] cnt_reg;
    logic             dout_reg;
    logic [CNT_W-1:0] limit;

    // proportional scaling keeps the limit monotonic in the setting
    assign limit = CNT_W'(filt_val) * CNT_W'(FILT_SCALE);

    // count samples of a level differing from the output
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_reg  <= '0;
            dout_reg <= 1'b0;
        end
        else if (!enable || filt_val == 4'h0)
        begin
            cnt_reg  <= '0;
            dout_reg <= din;
        end
        else if (din == dout_reg)
        begin
            cnt_reg <= '0;                                // any bounce restarts
        end
        else if (cnt_reg >= limit - CNT_W'(1))
        begin
            cnt_reg  <= '0;
            dout_reg <= din;                              // [R16]
        end
        else
        begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

    assign dout = dout_reg;

endmodule

// ===== logic/fault_filter_ctrl.sv
// Strobed register access was decided locally.
`timescale 1ns/1ps
//
// Summary of operation
// [R1] flag set when control, input enabled, fault
// [R2] read-then-write-0 clears flag if no fault
// [R3] writing 1 to a flag does nothing
// [R4] clearing summary flag clears all flags
// [R5] new fault restarts the clearing handshake
// [R6] two channel filter regs, ch0-3 only
// [R7] odd value high nibble, even low
// [R8] channel filter writes take effect immediately
// [R9] fault filter value bits 3-0, rest zero
// [R10] fault filter value write acts immediately
// [R11] control bits 7-4 enable fault filters
// [R12] control bits 3-0 enable fault inputs
// [R13] control register writable only when unprotected
// [R14] protection blocks writes, keeps values
// [R15] input state is OR of enabled inputs
// [R16] filter passes level after stable samples
// [R17] all registers synchronous, reset to defaults
//
module fault_filter_ctrl
    import fault_filter_pkg::*;
#(
    parameter int N_FAULT = 4,
    parameter int N_CHAN  = 4,
    parameter int CNT_W   = 8
)
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               nrst,
    // register port
    input  wire logic [7:0]         addr,
    input  wire logic [7:0]         wdata,
    input  wire logic               wr_en,
    input  wire logic               rd_en,
    output logic      [7:0]         rdata,
    // fault pins and channel inputs
    input  wire logic [N_FAULT-1:0] fault_pin,
    input  wire logic [N_CHAN-1:0]  chan_in,
    // filtered results toward the timer
    output logic [N_CHAN-1:0]       chan_filtered,
    output logic                    fault_input_state,
    output logic                    fault_summary_flag,
    output logic [N_FAULT-1:0]      fault_detect_flag
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [7:0]         chan_filt_reg [2];
    logic [3:0]         fault_filter_val_reg;
    logic [N_FAULT-1:0] fault_filter_en_reg;
    logic [N_FAULT-1:0] fault_input_en_reg;
    logic               fault_ctrl_en_reg;
    logic               write_protect_off_reg;
    logic [N_FAULT-1:0] flag_reg;
    logic [N_FAULT-1:0] flag_next;
    logic [N_FAULT-1:0] armed_reg;
    logic               summary_reg;
    logic               summary_next;
    logic [7:0]         rdata_reg;
    logic [N_CHAN-1:0]  chan_filt_out_reg;
    logic               instate_reg;

    // ------------------------------------------------------------------
    // filters
    // ------------------------------------------------------------------
    logic [N_FAULT-1:0] fault_filt_out;
    logic [N_CHAN-1:0]  chan_filt_out;
    logic [N_FAULT-1:0] fault_seen;

    // picks a channel's nibble from its shared register
    function automatic logic [3:0] chan_val(input logic [7:0] r, input int ch);
        return ch[0] ? r[ODD_VAL_LSB +: 4] : r[EVEN_VAL_LSB +: 4];    // [R7]
    endfunction

    // true when the address equals the given offset, for a read or a write
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] offs);
        return a == offs;
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < N_FAULT; gi++)
        begin : g_fault
            // filter value reaches the filter with no staging
            glitch_filter #(.CNT_W(CNT_W)) u_ffilt (
                .clk      (clk),
                .nrst     (nrst),
                .enable   (fault_filter_en_reg[gi]),
                .filt_val (fault_filter_val_reg),                 // [R10]
                .din      (fault_pin[gi]),
                .dout     (fault_filt_out[gi])
            );
        end
        for (gi = 0; gi < N_CHAN; gi++)
        begin : g_chan
            // filter registers cover channels 0-3 only; a filter is built for every channel
            glitch_filter #(.CNT_W(CNT_W)) u_cfilt (
                .clk      (clk),
                .nrst     (nrst),
                .enable   (1'b1),
                .filt_val (chan_val(chan_filt_reg[gi/2], gi)),    // [R6] [R8]
                .din      (chan_in[gi]),
                .dout     (chan_filt_out[gi])
            );
        end
    endgenerate

    // a fault counts only with control and input enabled
    assign fault_seen = fault_ctrl_en_reg ? (fault_filt_out & fault_input_en_reg)
                                          : '0;              // [R1]

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    // channel filter registers, live immediately
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            chan_filt_reg[0] <= CHAN_FILT_RST;                    // [R17]
            chan_filt_reg[1] <= CHAN_FILT_RST;
        end
        else if (wr_en)
        begin
            if (wr_hit(addr, CHAN_FILT01_OFFS))
                chan_filt_reg[0] <= wdata;                        // [R8]
            if (wr_hit(addr, CHAN_FILT23_OFFS))
                chan_filt_reg[1] <= wdata;
        end
    end

    // fault filter value; upper nibble is not stored
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            fault_filter_val_reg <= FAULT_FILT_RST;
        else if (wr_en && wr_hit(addr, FAULT_FILT_OFFS))
            fault_filter_val_reg <= wdata[3:0];                   // [R9]
    end

    // mode bits: fault control enable and write-protect release
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fault_ctrl_en_reg     <= MODE_CTRL_RST[MODE_FAULT_BIT];
            write_protect_off_reg <= MODE_CTRL_RST[MODE_WPOFF_BIT];
        end
        else if (wr_en && wr_hit(addr, MODE_CTRL_OFFS))
        begin
            fault_ctrl_en_reg     <= wdata[MODE_FAULT_BIT];
            write_protect_off_reg <= wdata[MODE_WPOFF_BIT];
        end
    end

    // fault input control, protected against stray writes
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fault_filter_en_reg <= FAULT_CTRL_RST[FILT_EN_LSB +: N_FAULT];
            fault_input_en_reg  <= FAULT_CTRL_RST[INPUT_EN_LSB +: N_FAULT];
        end
        else if (wr_en && wr_hit(addr, FAULT_CTRL_OFFS) && write_protect_off_reg) // [R13] [R14]
        begin
            fault_filter_en_reg <= wdata[FILT_EN_LSB +: N_FAULT];     // [R11]
            fault_input_en_reg  <= wdata[INPUT_EN_LSB +: N_FAULT];    // [R12]
        end
    end

    // ------------------------------------------------------------------
    // fault flags and clearing handshake
    // ------------------------------------------------------------------
    // next flag values; a live fault always outranks a clear
    always_comb
    begin
        logic stat_wr;
        stat_wr      = wr_en && wr_hit(addr, FAULT_STAT_OFFS);
        flag_next    = flag_reg;
        summary_next = summary_reg;
        if (stat_wr && summary_reg && !wdata[STAT_SUMMARY_BIT] && armed_reg != '0)
        begin
            summary_next = 1'b0;
            flag_next    = '0;                                    // [R4]
        end
        else if (stat_wr)
        begin
            for (int i = 0; i < N_FAULT; i++)
                if (armed_reg[i] && !wdata[i])
                    flag_next[i] = 1'b0;                          // [R2] [R3]
        end
        flag_next = flag_next | fault_seen;                       // [R1] [R2]
        if (fault_seen != '0)
            summary_next = 1'b1;
        else if (flag_next == '0)
            summary_next = 1'b0;
    end

    // flag and summary storage
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            flag_reg    <= '0;
            summary_reg <= 1'b0;
        end
        else
        begin
            flag_reg    <= flag_next;
            summary_reg <= summary_next;
        end
    end

    // arming: a status read with the flag set; a fresh fault disarms
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            armed_reg <= '0;
        else if (wr_en && wr_hit(addr, FAULT_STAT_OFFS))
            armed_reg <= '0;                                  // one write ends it
        else if (rd_en && wr_hit(addr, FAULT_STAT_OFFS))
            armed_reg <= flag_reg & ~fault_seen;
        else
            armed_reg <= armed_reg & ~fault_seen;                 // [R5]
    end

    // ------------------------------------------------------------------
    // read port and registered outputs
    // ------------------------------------------------------------------
    // read data valid in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata_reg <= 8'h00;
        else if (!rd_en)
            rdata_reg <= 8'h00;
        else
        begin
            unique case (addr)
                CHAN_FILT01_OFFS: rdata_reg <= chan_filt_reg[0];
                CHAN_FILT23_OFFS: rdata_reg <= chan_filt_reg[1];
                FAULT_FILT_OFFS:  rdata_reg <= {4'h0, fault_filter_val_reg}; // [R9]
                FAULT_CTRL_OFFS:  rdata_reg <= {fault_filter_en_reg, fault_input_en_reg};
                FAULT_STAT_OFFS:  rdata_reg <= {summary_reg, 1'b0, instate_reg,
                                                1'b0, flag_reg};
                MODE_CTRL_OFFS:   rdata_reg <= {6'h00, write_protect_off_reg,
                                                fault_ctrl_en_reg};
                default:          rdata_reg <= 8'h00;
            endcase
        end
    end

    // summary of enabled, filtered fault inputs
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            instate_reg <= 1'b0;
        else
            instate_reg <= |fault_seen;                           // [R15]
    end

    // channel outputs retimed so every port is a flop
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            chan_filt_out_reg <= '0;
        else
            chan_filt_out_reg <= chan_filt_out;
    end

    assign rdata              = rdata_reg;
    assign chan_filtered      = chan_filt_out_reg;
    assign fault_input_state  = instate_reg;
    assign fault_summary_flag = summary_reg;
    assign fault_detect_flag  = flag_reg;

endmodule

// ===== sim/fault_filter_ctrl_monitor.sv
`timescale 1ns/1ps
module fault_filter_ctrl_monitor
    import fault_filter_pkg::*;
#(
    parameter int N_FAULT = 4,
    parameter int N_CHAN  = 4,
    parameter int CNT_W   = 8
)
(
    // clock and reset
    input wire logic               clk,
    input wire logic               nrst,
    // register port
    input wire logic [7:0]         addr,
    input wire logic [7:0]         wdata,
    input wire logic               wr_en,
    input wire logic               rd_en,
    input wire logic [7:0]         rdata,
    // pins and results
    input wire logic [N_FAULT-1:0] fault_pin,
    input wire logic [N_CHAN-1:0]  chan_in,
    input wire logic [N_CHAN-1:0]  chan_filtered,
    input wire logic               fault_input_state,
    input wire logic               fault_summary_flag,
    input wire logic [N_FAULT-1:0] fault_detect_flag
);
    // ------------------------------------------------------------------
    // helpers and checks
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic wp_off_reg;
    logic filt0_en_reg;
    wire  st_wr = wr_en && addr == FAULT_STAT_OFFS;
    wire  ctl_a = addr == FAULT_CTRL_OFFS;

    // shadow of the protection bit, so blocked writes can be told apart
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            wp_off_reg <= 1'b0;
        else if (wr_en && addr == MODE_CTRL_OFFS)
            wp_off_reg <= wdata[MODE_WPOFF_BIT];
    end

    // shadow of filter enable 0: a held filter output keeps a fault live after the pin drops
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            filt0_en_reg <= FAULT_CTRL_RST[FILT_EN_LSB];
        else if (wr_en && ctl_a && wp_off_reg)
            filt0_en_reg <= wdata[FILT_EN_LSB];
    end

    // armed read: flag 0 up, input 0 unfiltered, no fault on pin 0 now or one edge ago
    sequence rd_stat;
        rd_en && addr == FAULT_STAT_OFFS && fault_detect_flag[0] && !fault_pin[0]
            && !$past(fault_pin[0]) && !filt0_en_reg;
    endsequence
    sequence wr_zero;
        st_wr && wdata == 8'h80 && !fault_pin[0];
    endsequence

    chk_rdata_idle: assert property (
        !rd_en |=> rdata == 8'h00) else $error("read data not zero after idle cycle");
    chk_filt_upper: assert property (
        rd_en && addr == FAULT_FILT_OFFS |=> rdata[7:4] == 4'h0)
        else $error("fault filter upper nibble not zero");
    chk_write_one: assert property (
        st_wr && wdata == 8'h8f |=> &(fault_detect_flag | ~$past(fault_detect_flag)))
        else $error("writing ones dropped a flag");
    chk_set_state: assert property (
        |(fault_detect_flag & ~$past(fault_detect_flag)) |-> fault_input_state)
        else $error("flag rose without live enabled fault");
    chk_flags_sum: assert property (
        fault_detect_flag != 4'h0 |-> fault_summary_flag)
        else $error("flag set while summary clear");
    chk_clear_cause: assert property (
        |($past(fault_detect_flag) & ~fault_detect_flag) |-> $past(st_wr))
        else $error("flag dropped without status write");
    chk_clear_seq: assert property (
        rd_stat ##1 wr_zero |=> !fault_detect_flag[0])
        else $error("armed clear did not drop flag");
    chk_filt_write: assert property (
        (wr_en && addr == CHAN_FILT01_OFFS) ##1 (rd_en && addr == CHAN_FILT01_OFFS)
        |=> rdata == $past(wdata, 2)) else $error("filter write not seen at once");
    chk_ctrl_protect: assert property (
        (rd_en && ctl_a) ##1 (wr_en && ctl_a && !wp_off_reg) ##1 (rd_en && ctl_a)
        |=> rdata == $past(rdata, 2)) else $error("protected write changed control");
endmodule

bind fault_filter_ctrl fault_filter_ctrl_monitor #(
    .N_FAULT(N_FAULT), .N_CHAN(N_CHAN), .CNT_W(CNT_W)
) mon_u (
    .clk, .nrst, .addr, .wdata, .wr_en, .rd_en, .rdata, .fault_pin, .chan_in,
    .chan_filtered, .fault_input_state, .fault_summary_flag, .fault_detect_flag
);

// ===== sim/pin_side_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// far side: fault pins and channel inputs
// ------------------------------------------------------------------
module pin_side_model
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // levels asked for
    input  wire logic [3:0] fault_lvl,
    input  wire logic [3:0] chan_lvl,
    // toward the block
    output logic      [3:0] fault_pin,
    output logic      [3:0] chan_in
);
    // pins move just after an edge, like already synchronised sources
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fault_pin <= 4'h0;
            chan_in   <= 4'h0;
        end
        else
        begin
            fault_pin <= fault_lvl;
            chan_in   <= chan_lvl;
        end
    end
endmodule

// ===== sim/fault_filter_ctrl_test.sv
`timescale 1ns/1ps
module fault_filter_ctrl_test
    import fault_filter_pkg::*;
;
    // ------------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------------
    logic        clk = 1'b0, nrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, ra, rv;
    logic [3:0]  fault_lvl = 4'h0, chan_lvl = 4'h0;
    logic [3:0]  fault_pin, chan_in, chan_filtered, fault_detect_flag;
    logic        fault_input_state, fault_summary_flag;
    logic [31:0] seed = 32'h62b10dbe;
    logic [7:0]  mdl [8] = '{default: 8'h00};
    int          n_errors = 0, compares = 0, cycles = 0;

    fault_filter_ctrl #(.N_FAULT(4), .N_CHAN(4), .CNT_W(8)) dut_u (
        .clk, .nrst, .addr, .wdata, .wr_en, .rd_en, .rdata, .fault_pin, .chan_in,
        .chan_filtered, .fault_input_state, .fault_summary_flag, .fault_detect_flag);
    pin_side_model pin_u (.clk, .nrst, .fault_lvl, .chan_lvl, .fault_pin, .chan_in);

    // 50 MHz clock
    always #10 clk = ~clk;

    // hang guard, far above the roughly 120 cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end

    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // expected register contents; status is judged separately
    function automatic logic [7:0] mx(input logic [7:0] a);
        return (a inside {[8'h26:8'h2b]} && a != FAULT_STAT_OFFS) ? mdl[a - 8'h26] : 8'h00;
    endfunction

    // outputs packed like the status register
    function automatic logic [7:0] outs();
        return {fault_summary_flag, 1'b0, fault_input_state, 1'b0, fault_detect_flag};
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        compares++;
        if (got !== want)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    // one bus cycle, back to back capable; for a read d is the expected data
    task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
        wr_en <= w;
        rd_en <= !w;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        #1;
        if (!w)
            chk(rdata, d);
        else if (a == FAULT_FILT_OFFS)
            mdl[2] = d & 8'h0f;
        else if (a == MODE_CTRL_OFFS)
            mdl[5] = d & 8'h03;
        else if (a == FAULT_CTRL_OFFS && mdl[5][MODE_WPOFF_BIT])
            mdl[3] = d;
        else if (a inside {CHAN_FILT01_OFFS, CHAN_FILT23_OFFS})
            mdl[a[0]] = d;
    endtask

    task automatic idle(input int n);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        idle(1);
        foreach (mdl[i])
            op(1'b0, 8'h26 + 8'(i), 8'h00);
        $display("reset values done");
        op(1'b1, MODE_CTRL_OFFS, 8'h02);
        for (int i = 0; i < 8; i++)
        begin
            ra = 8'h26 + 8'(i % 4);
            rv = xs();
            op(1'b1, ra, rv);
            op(1'b0, ra, mx(ra));
        end
        op(1'b1, MODE_CTRL_OFFS, 8'h00);
        op(1'b0, FAULT_CTRL_OFFS, mx(FAULT_CTRL_OFFS));
        op(1'b1, FAULT_CTRL_OFFS, ~mx(FAULT_CTRL_OFFS));
        op(1'b0, FAULT_CTRL_OFFS, mx(FAULT_CTRL_OFFS));
        $display("register access done");
        op(1'b1, CHAN_FILT01_OFFS, 8'h10);
        op(1'b1, CHAN_FILT23_OFFS, 8'h01);
        idle(1);
        chan_lvl <= 4'hf;
        idle(3);
        chk({4'h0, chan_filtered}, 8'h09);
        idle(FILT_SCALE + 4);
        chk({4'h0, chan_filtered}, 8'h0f);
        chan_lvl <= 4'h0;
        $display("channel filters done");
        // input 0 only, control still off
        op(1'b1, MODE_CTRL_OFFS, 8'h02);
        op(1'b1, FAULT_CTRL_OFFS, 8'h01);
        op(1'b1, FAULT_FILT_OFFS, 8'h00);
        fault_lvl <= 4'h1;
        idle(4);
        chk(outs(), 8'h00);
        op(1'b1, MODE_CTRL_OFFS, 8'h03);
        fault_lvl <= 4'h3;
        idle(4);
        chk(outs(), 8'ha1);
        fault_lvl <= 4'h0;
        idle(4);
        op(1'b0, FAULT_STAT_OFFS, 8'h81);
        op(1'b1, FAULT_STAT_OFFS, 8'h8f);
        op(1'b1, FAULT_STAT_OFFS, 8'h80);
        idle(1);
        chk(outs(), 8'h81);
        op(1'b0, FAULT_STAT_OFFS, 8'h81);
        op(1'b1, FAULT_STAT_OFFS, 8'h80);
        idle(1);
        chk({4'h0, fault_detect_flag}, 8'h00);
        fault_lvl <= 4'h1;
        idle(3);
        fault_lvl <= 4'h0;
        idle(4);
        op(1'b0, FAULT_STAT_OFFS, 8'h81);
        fault_lvl <= 4'h1;
        idle(2);
        fault_lvl <= 4'h0;
        idle(4);
        op(1'b1, FAULT_STAT_OFFS, 8'h80);
        idle(1);
        chk(outs(), 8'h81);
        op(1'b1, FAULT_CTRL_OFFS, 8'h03);
        fault_lvl <= 4'h2;
        idle(3);
        fault_lvl <= 4'h0;
        idle(4);
        op(1'b0, FAULT_STAT_OFFS, 8'h83);
        op(1'b1, FAULT_STAT_OFFS, 8'h00);
        idle(1);
        chk(outs(), 8'h00);
        $display("fault flags done");
        // filter value changed only while fault control is off
        op(1'b1, MODE_CTRL_OFFS, 8'h02);
        op(1'b1, FAULT_FILT_OFFS, 8'h02);
        op(1'b1, FAULT_CTRL_OFFS, 8'h11);
        op(1'b1, MODE_CTRL_OFFS, 8'h03);
        fault_lvl <= 4'h1;
        idle(3);
        fault_lvl <= 4'h0;
        idle(4);
        chk(outs(), 8'h00);
        fault_lvl <= 4'h1;
        idle(2 * FILT_SCALE + 6);
        chk(outs(), 8'ha1);
        fault_lvl <= 4'h0;
        $display("fault filter done");
        tally_and_finish();
    end
endmodule
